// File: rtl/gstt_pkg.sv
// Package for the gated sixteen bit timer: register map, fields and reset values
package gstt_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [2:0] GSTT_OFF_CTRL = 3'h0;
  localparam logic [2:0] GSTT_OFF_CNTL = 3'h1;
  localparam logic [2:0] GSTT_OFF_CNTH = 3'h2;
  localparam logic [2:0] GSTT_OFF_FLAG = 3'h3;
  localparam logic [2:0] GSTT_OFF_IEN = 3'h4;
  localparam logic [2:0] GSTT_OFF_GSRC = 3'h5;
  localparam logic [2:0] GSTT_OFF_INTC = 3'h6;
  localparam logic [2:0] GSTT_OFF_SYS = 3'h7;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int GSTT_B_ON = 0;
  localparam int GSTT_B_CS = 1;
  localparam int GSTT_B_SYNCDIS = 2;
  localparam int GSTT_B_OSCEN = 3;
  localparam int GSTT_B_PS_LO = 4;
  localparam int GSTT_B_GE = 6;
  localparam int GSTT_B_GINV = 7;
  localparam int GSTT_B_OVF = 0;
  localparam int GSTT_B_GSS = 1;
  localparam int GSTT_B_PERIPHERAL_IRQ_ENABLE = 6;
  localparam int GSTT_B_GIE = 7;
  localparam int GSTT_B_SLEEP = 0;
  localparam int GSTT_B_INTOSC = 1;
  localparam int GSTT_B_LCDSLP = 2;

  // ----------------------------------------------------------------
  // Reset values, count limit and interrupt vector
  // ----------------------------------------------------------------
  localparam logic [7:0] GSTT_RST_CTRL = 8'h00;
  localparam logic [7:0] GSTT_RST_GSRC = 8'h02;
  localparam logic [7:0] GSTT_RST_ZERO = 8'h00;
  localparam logic [15:0] GSTT_RST_CNT = 16'h0000;
  localparam logic [15:0] GSTT_CNT_MAX = 16'hFFFF;
  localparam logic [11:0] GSTT_VECTOR = 12'h004;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } gstt_bus_s;

endpackage

// File: rtl/gstt_timer.sv
// Gated sixteen bit timer/counter with register port
//
// The address map and the address-and-strobe port were decided locally.
`timescale 1ns/1ps

module gstt_timer
  import gstt_pkg::*;
#(
  parameter int PRESCALE_W = 3
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic porRst,
  input wire gstt_pkg::gstt_bus_s bus,
  output logic [7:0] rdata,
  input wire logic externalClockPin,
  input wire logic gatePin,
  input wire logic secondComparatorOutput,
  output logic irqRequest,
  output logic wakeRequest,
  output logic [11:0] irqVector,
  output logic lowPowerOscRun,
  output logic displayClockEnable,
  output logic [15:0] countValue
);
  import gstt_pkg::*;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] ctrl_r;
  logic [15:0] count_r;
  logic [15:0] count_nxt;
  logic ovf_r;
  logic ovfEn_r;
  logic gss_r;
  logic peripheral_irq_enable_r;
  logic gie_r;
  logic sleep_r;
  logic intOsc_r;
  logic lcdSleep_r;
  logic [PRESCALE_W-1:0] pre_r;
  logic sawFall_r;
  logic [1:0] ckSync_r;
  logic [1:0] gtSync_r;
  logic [1:0] cmpSync_r;
  logic ckPrev_r;
  logic ckRawPrev_r;

  // ----------------------------------------------------------------
  // Control decode
  // ----------------------------------------------------------------
  logic timerOn;
  logic extSel;
  logic syncDis;
  logic [1:0] psSel;
  logic wrCount;
  logic ckLevel;
  logic ckPrevLevel;
  logic rise;
  logic fall;
  logic gateRaw;
  logic gateOk;
  logic tick;
  logic preHit;
  logic inc;
  logic wrap;
  logic asyncMode;

  assign timerOn = ctrl_r[GSTT_B_ON];
  assign extSel = ctrl_r[GSTT_B_CS];
  assign syncDis = ctrl_r[GSTT_B_SYNCDIS] & extSel;
  assign psSel = ctrl_r[GSTT_B_PS_LO +: 2];
  assign asyncMode = extSel & syncDis;
  assign wrCount = bus.wr & (bus.addr == GSTT_OFF_CNTL || bus.addr == GSTT_OFF_CNTH);

  // Unsynchronised path still samples the pin once; true async counting
  // would need its own clock domain, which this block does not have.
  assign ckLevel = syncDis ? externalClockPin : ckSync_r[1];
  assign ckPrevLevel = syncDis ? ckRawPrev_r : ckPrev_r;
  assign rise = ckLevel & ~ckPrevLevel;
  assign fall = ~ckLevel & ckPrevLevel;

  assign gateRaw = gss_r ? gtSync_r[1] : cmpSync_r[1];
  assign gateOk = ~ctrl_r[GSTT_B_GE] | (gateRaw == ctrl_r[GSTT_B_GINV]);

  // Fosc/4 taken as one tick per clock; external needs a prior fall
  assign tick = extSel ? (rise & sawFall_r) : 1'b1;

  // Prescaler hit when low bits of pre_r reach one less than the divide ratio
  always_comb begin
    unique case (psSel)
      2'b00: preHit = 1'b1;
      2'b01: preHit = pre_r[0];
      2'b10: preHit = &pre_r[1:0];
      2'b11: preHit = &pre_r[2:0];
    endcase
  end

  assign inc = timerOn & gateOk & tick & preHit & (~sleep_r | asyncMode);
  assign wrap = inc & (count_r == GSTT_CNT_MAX);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ckSync_r <= 2'b00;
      gtSync_r <= 2'b00;
      cmpSync_r <= 2'b00;
      ckPrev_r <= 1'b0;
      ckRawPrev_r <= 1'b0;
    end else begin
      ckSync_r <= {ckSync_r[0], externalClockPin};
      gtSync_r <= {gtSync_r[0], gatePin};
      cmpSync_r <= {cmpSync_r[0], secondComparatorOutput};
      ckPrev_r <= ckSync_r[1];
      ckRawPrev_r <= externalClockPin;
    end
  end

  // ----------------------------------------------------------------
  // Falling edge arming
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sawFall_r <= 1'b0;
    end else if (wrCount || !timerOn) begin
      sawFall_r <= 1'b0;
    end else if (fall) begin
      sawFall_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pre_r <= '0;
    end else if (wrCount) begin
      pre_r <= '0;
    end else if (timerOn && gateOk && tick && (!sleep_r || asyncMode)) begin
      pre_r <= preHit ? '0 : pre_r + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Counter, kept across ordinary resets
  // ----------------------------------------------------------------
  always_comb begin
    count_nxt = count_r;
    if (bus.wr && bus.addr == GSTT_OFF_CNTL) begin
      count_nxt = {count_r[15:8], bus.wdata};
    end else if (bus.wr && bus.addr == GSTT_OFF_CNTH) begin
      count_nxt = {bus.wdata, count_r[7:0]};
    end else if (inc) begin
      count_nxt = count_r + 16'h0001;
    end
  end

  // Only power-on clears it; the documented value there is unknown
  always_ff @(posedge clock or posedge porRst) begin
    if (porRst) begin
      count_r <= GSTT_RST_CNT;
    end else begin
      count_r <= count_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Control register, power-on reset only
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge porRst) begin
    if (porRst) begin
      ctrl_r <= GSTT_RST_CTRL;
    end else if (bus.wr && bus.addr == GSTT_OFF_CTRL) begin
      ctrl_r <= bus.wdata;
    end
  end

  // ----------------------------------------------------------------
  // Flag and enable registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ovf_r <= 1'b0;
    end else if (wrap) begin
      ovf_r <= 1'b1;
    end else if (bus.wr && bus.addr == GSTT_OFF_FLAG) begin
      ovf_r <= bus.wdata[GSTT_B_OVF];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ovfEn_r <= 1'b0;
      gss_r <= GSTT_RST_GSRC[GSTT_B_GSS];
      peripheral_irq_enable_r <= 1'b0;
      gie_r <= 1'b0;
      intOsc_r <= 1'b0;
      lcdSleep_r <= 1'b0;
    end else if (bus.wr) begin
      if (bus.addr == GSTT_OFF_IEN) ovfEn_r <= bus.wdata[GSTT_B_OVF];
      if (bus.addr == GSTT_OFF_GSRC) gss_r <= bus.wdata[GSTT_B_GSS];
      if (bus.addr == GSTT_OFF_INTC) begin
        peripheral_irq_enable_r <= bus.wdata[GSTT_B_PERIPHERAL_IRQ_ENABLE];
        gie_r <= bus.wdata[GSTT_B_GIE];
      end
      if (bus.addr == GSTT_OFF_SYS) begin
        intOsc_r <= bus.wdata[GSTT_B_INTOSC];
        lcdSleep_r <= bus.wdata[GSTT_B_LCDSLP];
      end
    end
  end

  // Sleep is left by a wake request as well as by software
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sleep_r <= 1'b0;
    end else if (sleep_r && timerOn && ovf_r && ovfEn_r && peripheral_irq_enable_r) begin
      sleep_r <= 1'b0;
    end else if (bus.wr && bus.addr == GSTT_OFF_SYS) begin
      sleep_r <= bus.wdata[GSTT_B_SLEEP];
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irqRequest <= 1'b0;
      wakeRequest <= 1'b0;
      irqVector <= 12'h000;
      lowPowerOscRun <= 1'b0;
      displayClockEnable <= 1'b0;
    end else begin
      irqRequest <= ovf_r & ovfEn_r & peripheral_irq_enable_r & gie_r;
      wakeRequest <= sleep_r & timerOn & ovf_r & ovfEn_r & peripheral_irq_enable_r;
      irqVector <= gie_r ? GSTT_VECTOR : 12'h000;
      lowPowerOscRun <= ctrl_r[GSTT_B_OSCEN] & intOsc_r;
      displayClockEnable <= ctrl_r[GSTT_B_OSCEN] & intOsc_r & (~sleep_r | lcdSleep_r);
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      countValue <= GSTT_RST_CNT;
    end else begin
      countValue <= count_nxt;
    end
  end

  // Reads sample count_r one byte per access with no latch, so a running count can tear between bytes
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdata <= GSTT_RST_ZERO;
    end else if (bus.rd) begin
      unique case (bus.addr)
        GSTT_OFF_CTRL: rdata <= ctrl_r;
        GSTT_OFF_CNTL: rdata <= count_r[7:0];
        GSTT_OFF_CNTH: rdata <= count_r[15:8];
        GSTT_OFF_FLAG: rdata <= {7'h00, ovf_r};
        GSTT_OFF_IEN: rdata <= {7'h00, ovfEn_r};
        GSTT_OFF_GSRC: rdata <= {6'h00, gss_r, 1'b0};
        GSTT_OFF_INTC: rdata <= {gie_r, peripheral_irq_enable_r, 6'h00};
        GSTT_OFF_SYS: rdata <= {5'h00, lcdSleep_r, intOsc_r, sleep_r};
      endcase
    end else begin
      rdata <= GSTT_RST_ZERO;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence wrapSeq;
    wrap;
  endsequence

  overflow_flag_a: assert property (@(posedge clock) disable iff (rst)
    wrapSeq |=> ovf_r && count_r == 16'h0000)
    else $error("wrap did not set flag");

  irq_gating_a: assert property (@(posedge clock) disable iff (rst)
    irqRequest |-> $past(ovf_r && ovfEn_r && peripheral_irq_enable_r && gie_r))
    else $error("irq without all enables");

  gate_hold_a: assert property (@(posedge clock) disable iff (rst || porRst)
    (timerOn && ctrl_r[GSTT_B_GE] && gateRaw != ctrl_r[GSTT_B_GINV] && !bus.wr)
      |=> $stable(count_r))
    else $error("count moved while gated");

  off_hold_a: assert property (@(posedge clock) disable iff (rst || porRst)
    (!timerOn && !bus.wr) |=> $stable(count_r))
    else $error("count moved while off");

  sleep_freeze_a: assert property (@(posedge clock) disable iff (rst || porRst)
    (sleep_r && !asyncMode && !bus.wr) |=> $stable(count_r))
    else $error("count moved in sleep");

  write_load_a: assert property (@(posedge clock) disable iff (rst || porRst)
    (bus.wr && bus.addr == GSTT_OFF_CNTL) |=> count_r[7:0] == $past(bus.wdata))
    else $error("low byte write not loaded");

  pre_clear_a: assert property (@(posedge clock) disable iff (rst)
    wrCount |=> pre_r == '0)
    else $error("prescaler not cleared");

  step_one_a: assert property (@(posedge clock) disable iff (rst || porRst)
    (inc && !bus.wr) |=> count_r == $past(count_r) + 16'h0001)
    else $error("count step wrong");

  fall_first_a: assert property (@(posedge clock) disable iff (rst || porRst)
    (extSel && !sawFall_r && !bus.wr) |=> $stable(count_r))
    else $error("counted before falling edge");

  wake_a: assert property (@(posedge clock) disable iff (rst)
    (sleep_r && timerOn && ovf_r && ovfEn_r && peripheral_irq_enable_r) |=> wakeRequest && !sleep_r)
    else $error("no wake on overflow");

  sequence countStepSeq;
    count_r == $past(count_r) + 16'h0001;
  endsequence

  irq_level_a: assert property (@(posedge clock) disable iff (rst)
    (ovf_r && ovfEn_r && peripheral_irq_enable_r && gie_r) |=> irqRequest)
    else $error("irq missing with all enables");

  vector_a: assert property (@(posedge clock) disable iff (rst)
    gie_r |=> irqVector == GSTT_VECTOR)
    else $error("vector not presented");

  display_sleep_a: assert property (@(posedge clock) disable iff (rst)
    (sleep_r && !lcdSleep_r) |=> !displayClockEnable)
    else $error("display clock ran in sleep");

  osc_ignored_a: assert property (@(posedge clock) disable iff (rst)
    !intOsc_r |=> !lowPowerOscRun)
    else $error("oscillator ran without internal clock");

  pin_gate_a: assert property (@(posedge clock) disable iff (rst || porRst)
    (timerOn && ctrl_r[GSTT_B_GE] && gss_r && gtSync_r[1] == ctrl_r[GSTT_B_GINV]
      && !extSel && preHit && !sleep_r && !bus.wr) |=> countStepSeq)
    else $error("pin gate did not open");

  ext_rise_a: assert property (@(posedge clock) disable iff (rst || porRst)
    (timerOn && extSel && sawFall_r && rise && preHit && !ctrl_r[GSTT_B_GE] && !sleep_r
      && !bus.wr) |=> countStepSeq)
    else $error("external rise not counted");

  async_sleep_a: assert property (@(posedge clock) disable iff (rst || porRst)
    (sleep_r && asyncMode && timerOn && sawFall_r && rise && preHit && !ctrl_r[GSTT_B_GE]
      && !bus.wr) |=> countStepSeq)
    else $error("asynchronous counter froze in sleep");

endmodule

// File: tb/gstt_ext_src.sv
// Far side model: external count clock, gate pin and comparator level
`timescale 1ns/1ps

module gstt_ext_src (
  input wire logic clock,
  output logic extClk,
  output logic gateLevel,
  output logic compLevel
);
  initial begin
    extClk = 1'b0;
    gateLevel = 1'b0;
    compLevel = 1'b0;
  end

  // Clock idles low between bursts, so each burst opens on a rising edge
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge clock);
      extClk <= 1'b1;
      repeat (4) @(posedge clock);
      extClk <= 1'b0;
      repeat (3) @(posedge clock);
    end
  endtask

  task automatic setGate(input logic g, input logic c);
    @(posedge clock);
    gateLevel <= g;
    compLevel <= c;
  endtask
endmodule

// File: tb/tb.sv
// Self-checking bench for the gated sixteen bit timer
`timescale 1ns/1ps

module tb;
  import gstt_pkg::*;
  logic clock;
  logic rst;
  logic porRst;
  gstt_bus_s bus;
  logic [7:0] rdata;
  logic extClk;
  logic gateLevel;
  logic compLevel;
  logic irqRequest;
  logic wakeRequest;
  logic [11:0] irqVector;
  logic lowPowerOscRun;
  logic displayClockEnable;
  logic [15:0] countValue;
  logic [15:0] c;
  logic [15:0] w;
  int bad_count = 0;
  int checks_done = 0;
  int seed = 32'h9D05;
  int wakeSeen = 0;
  logic [15:0] wrQ [$];
  logic [7:0] gCtl [7] = '{8'hC1, 8'hC1, 8'h41, 8'h41, 8'h41, 8'h01, 8'hC1};
  logic [7:0] gSrc [7] = '{8'h02, 8'h02, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [6:0] gPin = 7'h7E;
  logic [6:0] gComp = 7'h70;
  logic [6:0] gRun = 7'h6A;

  gstt_timer #(.PRESCALE_W(3)) gstt_timer_inst (.clock(clock), .rst(rst), .porRst(porRst),
    .bus(bus), .rdata(rdata), .externalClockPin(extClk), .gatePin(gateLevel),
    .secondComparatorOutput(compLevel), .irqRequest(irqRequest), .wakeRequest(wakeRequest),
    .irqVector(irqVector), .lowPowerOscRun(lowPowerOscRun),
    .displayClockEnable(displayClockEnable), .countValue(countValue));
  gstt_ext_src gstt_ext_src_inst (.clock(clock), .extClk(extClk), .gateLevel(gateLevel),
    .compLevel(compLevel));

  // ------------------------------------------------------------
  // Bus and compare helpers
  // ------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Wake is a one-cycle pulse, so it is counted as it happens
  always @(negedge clock) begin
    if (wakeRequest === 1'b1) wakeSeen++;
  end

  // Behavioural count: start plus ticks over the prescale ratio, modulo sixteen bits
  function automatic logic [15:0] modelCount(input int start, input int ticks, input int ratio);
    return 16'((start + ticks / ratio) % 65536);
  endfunction

  task automatic end_of_test();
    if (bad_count == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Tolerance of one count covers the unknown phase of the prescaler
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g, input bit t);
    checks_done++;
    if (!(g === e || (t && (g === e + 16'h1 || g === e - 16'h1)))) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clock);
    bus.wr <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clock);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clock);
    bus.rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic rchk(input logic [2:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk("register", {8'h00, e}, {8'h00, d}, 1'b0);
  endtask

  task automatic rd16(output logic [15:0] v);
    rd(GSTT_OFF_CNTL, v[7:0]);
    rd(GSTT_OFF_CNTH, v[15:8]);
  endtask

  // Stopped timer is cleared, run for 66 cycles, then stopped and read
  task automatic measure(input logic [7:0] ctl, output logic [15:0] v);
    wr(GSTT_OFF_CTRL, 8'h00);
    wr(GSTT_OFF_CNTL, 8'h00);
    wr(GSTT_OFF_CNTH, 8'h00);
    wr(GSTT_OFF_CTRL, ctl);
    repeat (64) @(posedge clock);
    wr(GSTT_OFF_CTRL, 8'h00);
    rd16(v);
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    rst = 1'b1;
    porRst = 1'b1;
    bus = '0;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    porRst <= 1'b0;
    rchk(GSTT_OFF_CTRL, GSTT_RST_CTRL);
    rchk(GSTT_OFF_GSRC, GSTT_RST_GSRC);
    rchk(GSTT_OFF_FLAG, 8'h00);
    rchk(GSTT_OFF_IEN, 8'h00);
    rchk(GSTT_OFF_INTC, 8'h00);
    for (int i = 0; i < 4; i++) begin
      c = 16'($random(seed));
      wrQ.push_back(c);
      wr(GSTT_OFF_CNTL, c[7:0]);
      wr(GSTT_OFF_CNTH, c[15:8]);
      rd16(w);
      chk("count", wrQ[0], w, 1'b0);
      chk("count mirror", wrQ.pop_front(), countValue, 1'b0);
    end
    for (int p = 0; p < 4; p++) begin
      measure({2'b00, 2'(p), 4'h1}, c);
      chk("prescaled count", modelCount(0, 66, 1 << p), c, 1'b1);
    end
    for (int i = 0; i < 7; i++) begin
      wr(GSTT_OFF_GSRC, gSrc[i]);
      gstt_ext_src_inst.setGate(gPin[i], gComp[i]);
      measure(gCtl[i], c);
      chk("gated count", gRun[i] ? 16'h0042 : 16'h0000, c, 1'b1);
    end
    // First rise after enable has no falling edge before it, so it is not counted
    for (int s = 0; s < 2; s++) begin
      fork
        measure(s ? 8'h07 : 8'h03, c);
        begin
          repeat (8) @(posedge clock);
          gstt_ext_src_inst.pulses(5);
        end
      join
      chk("external count", modelCount(0, 5 - 1, 1), c, 1'b0);
    end
    wr(GSTT_OFF_FLAG, 8'h00);
    wr(GSTT_OFF_CNTL, 8'hF0);
    wr(GSTT_OFF_CNTH, 8'hFF);
    wr(GSTT_OFF_CTRL, 8'h01);
    repeat (18) @(posedge clock);
    wr(GSTT_OFF_CTRL, 8'h00);
    rd16(c);
    chk("wrapped count", modelCount(16'hFFF0, 20, 1), c, 1'b1);
    rchk(GSTT_OFF_FLAG, 8'h01);
    for (int i = 0; i < 8; i++) begin
      wr(GSTT_OFF_IEN, {7'h00, i[0]});
      wr(GSTT_OFF_INTC, {i[2], i[1], 6'h00});
      repeat (2) @(posedge clock);
      chk("irq", {15'h0000, &i[2:0]}, {15'h0000, irqRequest}, 1'b0);
      chk("vector", i[2] ? {4'h0, GSTT_VECTOR} : 16'h0000, {4'h0, irqVector}, 1'b0);
    end
    wr(GSTT_OFF_FLAG, 8'h00);
    repeat (2) @(posedge clock);
    chk("irq cleared", 16'h0000, {15'h0000, irqRequest}, 1'b0);
    for (int i = 0; i < 16; i++) begin
      wr(GSTT_OFF_CTRL, {4'h0, i[0], 3'h0});
      wr(GSTT_OFF_SYS, {5'h00, i[2], i[1], i[3]});
      repeat (2) @(posedge clock);
      chk("osc run", {15'h0000, i[0] & i[1]}, {15'h0000, lowPowerOscRun}, 1'b0);
      chk("display clock", {15'h0000, i[0] & i[1] & (!i[3] | i[2])},
        {15'h0000, displayClockEnable}, 1'b0);
    end
    wr(GSTT_OFF_SYS, 8'h01);
    measure(8'h01, c);
    chk("sleep count", 16'h0000, c, 1'b0);
    // Asynchronous counter keeps running in sleep and its wrap wakes the block
    wr(GSTT_OFF_CNTL, 8'hFE);
    wr(GSTT_OFF_CNTH, 8'hFF);
    wr(GSTT_OFF_CTRL, 8'h07);
    gstt_ext_src_inst.pulses(4);
    wr(GSTT_OFF_CTRL, 8'h00);
    rd16(c);
    chk("sleep async count", modelCount(16'hFFFE, 4 - 1, 1), c, 1'b0);
    chk("wake pulses", 16'h0001, 16'(wakeSeen), 1'b0);
    chk("irq after wake", 16'h0001, {15'h0000, irqRequest}, 1'b0);
    rchk(GSTT_OFF_FLAG, 8'h01);
    rchk(GSTT_OFF_SYS, 8'h00);
    wr(GSTT_OFF_SYS, 8'h00);
    wr(GSTT_OFF_CNTL, 8'h34);
    wr(GSTT_OFF_CNTH, 8'h12);
    wr(GSTT_OFF_CTRL, 8'h30);
    @(posedge clock);
    rst <= 1'b1;
    @(posedge clock);
    rst <= 1'b0;
    rd16(c);
    chk("kept count", 16'h1234, c, 1'b0);
    rchk(GSTT_OFF_CTRL, 8'h30);
    end_of_test();
  end

  // Whole run needs about fourteen hundred cycles; this bound only cuts a hang
  initial begin
    repeat (20000) @(posedge clock);
    bad_count++;
    end_of_test();
  end
endmodule
